// >>> hes_bank.sv
// host error status bank: sticky fault registers and summary flag
`timescale 1ns/1ps
module hes_bank
    import hes_pkg::*;
(
    input  wire logic            clk_sys_i,
    input  wire logic            rstn_i,
    input  wire hes_fault_s      fault_i,
    input  wire hes_throttle_s   throttle_i,
    input  wire logic [7:0]      input_pin_level_i,
    input  wire logic [7:0]      input_error_mask_i,
    input  wire logic            vid_mode_older_i,
    input  wire hes_sleep_e      sleep_state_i,
    input  wire hes_sleep_mask_s sleep_mask_volt_b_i,
    input  wire hes_sleep_mask_s sleep_mask_diode_i,
    input  wire hes_sleep_mask_s sleep_mask_inputs_i,
    input  wire hes_sleep_mask_s sleep_mask_fans_i,
    input  wire logic            reg_wr_i,
    input  wire logic            reg_rd_i,
    input  wire logic [7:0]      reg_addr_i,
    input  wire logic [7:0]      reg_wdata_i,
    output logic [7:0]           reg_rdata_o,
    output logic                 reg_hit_o,
    output logic                 host_error_o
);

    logic [7:0] raw [HES_NUM_REGS];
    logic [7:0] fixed_s3 [HES_NUM_REGS];
    logic [7:0] opt_s1 [HES_NUM_REGS];
    logic [7:0] opt_s3 [HES_NUM_REGS];
    logic [7:0] opt_s45 [HES_NUM_REGS];
    logic [7:0] set_v [HES_NUM_REGS];
    logic [7:0] clr_v [HES_NUM_REGS];
    logic [7:0] val [HES_NUM_REGS];
    logic [7:0] thr_events;
    logic [7:0] next_rdata;
    logic       next_hit;

    localparam logic [7:0] ADDRS [HES_NUM_REGS] = '{HES_ADDR_VOLT_A,
        HES_ADDR_VOLT_B, HES_ADDR_DIODE, HES_ADDR_THROTTLE,
        HES_ADDR_INPUTS, HES_ADDR_FANS};
    localparam logic [7:0] MASKS [HES_NUM_REGS] = '{HES_MASK_VOLT_A,
        HES_MASK_VOLT_B, HES_MASK_DIODE, HES_MASK_THROTTLE,
        HES_MASK_INPUTS, HES_MASK_FANS};

    // sleep listing: fixed bits drop in S3 and S4/5, optional bits
    // only when the host mask asks for it, except fan bits, always dropped in S4/5
    localparam logic [7:0] FIXED_VOLT_B = 8'h41;
    localparam logic [7:0] FIXED_DIODE  = 8'h18;
    localparam logic [7:0] OPT_VOLT_B   = 8'h30;
    localparam logic [7:0] OPT_DIODE    = 8'hc3;

    // address decode, used for both read and write
    function automatic int addr_index(input logic [7:0] a);
        int idx;
        idx = -1;
        for (int k = 0; k < HES_NUM_REGS; k++)
            if (a == ADDRS[k])
                idx = k;
        return idx;
    endfunction

    hes_throttle_bin u_thr
    (
        .thr_i    (throttle_i),
        .events_o (thr_events)
    );

    // raw condition per bit
    always_comb
    begin
        raw[0] = {1'b0, fault_i.chan_limit_fault[3], 3'b000,
                  fault_i.chan_limit_fault[2:0]};
        raw[1] = {fault_i.further_limit_fault, 3'b000,
                  fault_i.chan5_limit_fault};
        raw[2] = {fault_i.diode2_primary_fault,
                  fault_i.diode1_primary_fault, 1'b0,
                  fault_i.core_supply_mismatch,
                  fault_i.fuse_monitor_input & vid_mode_older_i,
                  1'b0, fault_i.diode2_secondary_fault,
                  fault_i.diode1_secondary_fault};
        raw[3] = thr_events;
        raw[4] = ~input_pin_level_i & ~input_error_mask_i;
        raw[5] = {4'h0, fault_i.fan_tach_fault};
    end

    // sleep suppression: fixed sources in S3 and S4/5 per listing,
    // optional sources by mask (fans always in S4/5); unlisted (volt B bit 7) never suppressed
    always_comb
    begin
        fixed_s3[0] = HES_MASK_VOLT_A;
        fixed_s3[1] = FIXED_VOLT_B;
        fixed_s3[2] = FIXED_DIODE;
        fixed_s3[3] = HES_MASK_THROTTLE;
        fixed_s3[4] = 8'h00;
        fixed_s3[5] = 8'h00;
        for (int k = 0; k < HES_NUM_REGS; k++)
        begin
            opt_s1[k]  = 8'h00;
            opt_s3[k]  = 8'h00;
            opt_s45[k] = 8'h00;
        end
        opt_s3[1]  = sleep_mask_volt_b_i.s3 & OPT_VOLT_B;
        opt_s45[1] = sleep_mask_volt_b_i.s45 & OPT_VOLT_B;
        opt_s3[2]  = sleep_mask_diode_i.s3 & OPT_DIODE;
        opt_s45[2] = sleep_mask_diode_i.s45 & OPT_DIODE;
        opt_s1[4]  = sleep_mask_inputs_i.s1;
        opt_s3[4]  = sleep_mask_inputs_i.s3;
        opt_s45[4] = sleep_mask_inputs_i.s45;
        opt_s1[5]  = sleep_mask_fans_i.s1 & HES_MASK_FANS;
        opt_s3[5]  = sleep_mask_fans_i.s3 & HES_MASK_FANS;
        opt_s45[5] = HES_MASK_FANS;
    end

    always_comb
    begin
        for (int k = 0; k < HES_NUM_REGS; k++)
        begin
            unique case (sleep_state_i)
                HES_SLEEP_S0:  set_v[k] = raw[k];
                HES_SLEEP_S1:  set_v[k] = raw[k] & ~opt_s1[k];
                HES_SLEEP_S3:  set_v[k] = raw[k] & ~(fixed_s3[k] | opt_s3[k]);
                HES_SLEEP_S45: set_v[k] = raw[k] &
                                          ~(fixed_s3[k] | opt_s45[k]);
            endcase
            clr_v[k] = (reg_wr_i && addr_index(reg_addr_i) == k)
                       ? reg_wdata_i : 8'h00;
        end
    end

    genvar g;
    generate
        for (g = 0; g < HES_NUM_REGS; g++)
        begin : g_reg
            hes_sticky_reg #(.IMPL_MASK(MASKS[g])) u_reg
            (
                .clk_sys_i (clk_sys_i),
                .rstn_i    (rstn_i),
                .set_i     (set_v[g]),
                .clr_i     (clr_v[g]),
                .value_o   (val[g])
            );
        end
    endgenerate

    // summary flag: throttle bins excluded
    always_comb
    begin
        host_error_o = 1'b0;
        for (int k = 0; k < HES_NUM_REGS; k++)
            host_error_o = host_error_o |
                ((k == 3) ? |(val[k] & ~HES_THR_BIN_MASK) : |val[k]);
    end

    always_comb
    begin
        next_rdata = 8'h00;
        next_hit   = 1'b0;
        for (int k = 0; k < HES_NUM_REGS; k++)
            if (addr_index(reg_addr_i) == k)
            begin
                next_rdata = val[k];
                next_hit   = 1'b1;
            end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            reg_rdata_o <= HES_RESET_VALUE;
            reg_hit_o   <= 1'b0;
        end
        else if (reg_rd_i)
        begin
            reg_rdata_o <= next_rdata;
            reg_hit_o   <= next_hit;
        end
    end

    // the clear seen by the register at an edge is the one sampled there,
    // so hold checks pair the past value with the past clear
    AST_STICKY_HOLD: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        $past(val[0][0]) && !$past(clr_v[0][0]) |-> val[0][0])
        else $error("volt bit cleared without write");

    AST_SET_WINS: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        set_v[2][4] |=> val[2][4])
        else $error("mismatch fault not captured");

    AST_RSVD_ZERO: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (val[0] & ~HES_MASK_VOLT_A) == 8'h00 && val[5][7:4] == 4'h0)
        else $error("reserved bit set");

    AST_ONE_BIN: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        throttle_i.done && throttle_i.active_count < HES_THR_FULL
        |-> $onehot(thr_events[5:1]))
        else $error("throttle bin not one-hot");

    AST_BIN_NO_SUM: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        val[0] == 8'h00 && val[1] == 8'h00 && val[2] == 8'h00
        && val[4] == 8'h00 && val[5] == 8'h00 && !val[3][7]
        |-> !host_error_o)
        else $error("bins raised summary");

    AST_SUM_ON: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        |val[4] |-> host_error_o)
        else $error("summary missing");

    AST_FUSE_MODE: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        !vid_mode_older_i |-> !set_v[2][3])
        else $error("fuse set outside older mode");

    AST_INPUT_MASK: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        sleep_state_i == HES_SLEEP_S0 && !input_pin_level_i[0]
        && !input_error_mask_i[0] |=> val[4][0])
        else $error("low input not captured");

    AST_S3_SUPPRESS: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        sleep_state_i == HES_SLEEP_S3 |-> set_v[0] == 8'h00)
        else $error("voltage fault not suppressed in S3");

    AST_VOLT_A_SET: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        sleep_state_i == HES_SLEEP_S0 && fault_i.chan_limit_fault[0]
        |=> val[0][0])
        else $error("channel one fault not captured");

    AST_CH4_SET: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        sleep_state_i == HES_SLEEP_S0 && fault_i.chan_limit_fault[3]
        |=> val[0][6])
        else $error("channel four fault not captured");

    AST_CH5_SET: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        sleep_state_i == HES_SLEEP_S0 && fault_i.chan5_limit_fault
        |=> val[1][0])
        else $error("channel five fault not captured");

    // the last further channel is never sleep-masked
    AST_FURTHER_SET: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        fault_i.further_limit_fault[3] |=> val[1][7])
        else $error("further channel fault not captured");

    AST_DIODE_SEC: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        sleep_state_i == HES_SLEEP_S0 && fault_i.diode2_secondary_fault
        |=> val[2][1])
        else $error("secondary diode fault not captured");

    AST_DIODE_PRI: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        sleep_state_i == HES_SLEEP_S0 && fault_i.diode1_primary_fault
        |=> val[2][6])
        else $error("primary diode fault not captured");

    AST_FUSE_SET: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        sleep_state_i == HES_SLEEP_S0 && vid_mode_older_i
        && fault_i.fuse_monitor_input |=> val[2][3])
        else $error("fuse fault not captured");

    AST_CORE_SET: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        sleep_state_i == HES_SLEEP_S0 && fault_i.core_supply_mismatch
        |=> val[2][4])
        else $error("core mismatch not captured");

    AST_ANY_THR: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        throttle_i.done && throttle_i.active_count != 9'h000
        |-> thr_events[HES_THR_ANY_BIT])
        else $error("throttle event bit missing");

    AST_FULL_THR: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        throttle_i.done && throttle_i.active_count == HES_THR_FULL
        |-> thr_events[HES_THR_FULL_BIT])
        else $error("full throttle bit missing");

    AST_LIM_THR: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        throttle_i.done && throttle_i.active_count > throttle_i.user_limit
        |-> thr_events[HES_THR_LIM_BIT])
        else $error("throttle limit bit missing");

    AST_LIM_SUM: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        val[3][HES_THR_LIM_BIT] |-> host_error_o)
        else $error("throttle limit missing from summary");

    AST_INPUT_SUPPRESS: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        input_error_mask_i[7] |-> !set_v[4][7])
        else $error("masked input still sets");

    AST_FAN_SET: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        sleep_state_i == HES_SLEEP_S0 && fault_i.fan_tach_fault[0]
        |=> val[5][0])
        else $error("fan fault not captured");

    AST_FAN_RSVD_READ: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        reg_rd_i && reg_addr_i == HES_ADDR_FANS
        |=> reg_rdata_o[7:4] == 4'h0)
        else $error("fan reserved bits read nonzero");

    AST_CLEAR_TAKES: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        $past(clr_v[1][0]) && !$past(set_v[1][0]) |-> !val[1][0])
        else $error("clear of idle fault ignored");

    AST_CLEAR_BLOCKED: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        set_v[4][0] |=> val[4][0])
        else $error("clear won over active fault");

    AST_S1_KEEP: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        sleep_state_i == HES_SLEEP_S1 |-> set_v[0] == raw[0])
        else $error("voltage fault masked in S1");

    AST_FAN_S45: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        sleep_state_i == HES_SLEEP_S45 |-> set_v[5] == 8'h00)
        else $error("fan fault not suppressed in S4/5");

    AST_RSVD_VOLT_B: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (val[1] & ~HES_MASK_VOLT_B) == 8'h00)
        else $error("reserved channel bit set");

    AST_RSVD_DIODE: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (val[2] & ~HES_MASK_DIODE) == 8'h00)
        else $error("reserved diode bit set");

endmodule

// >>> hes_pkg.sv
// package for the host error status bank: offsets, fields, sleep codes
package hes_pkg;

    localparam logic [7:0] HES_ADDR_VOLT_A   = 8'h49;
    localparam logic [7:0] HES_ADDR_VOLT_B   = 8'h4a;
    localparam logic [7:0] HES_ADDR_DIODE    = 8'h4b;
    localparam logic [7:0] HES_ADDR_THROTTLE = 8'h4c;
    localparam logic [7:0] HES_ADDR_INPUTS   = 8'h4e;
    localparam logic [7:0] HES_ADDR_FANS     = 8'h4f;

    localparam logic [7:0] HES_RESET_VALUE   = 8'h00;

    // implemented-bit masks; reserved bits read zero
    localparam logic [7:0] HES_MASK_VOLT_A   = 8'h47;
    localparam logic [7:0] HES_MASK_VOLT_B   = 8'hf1;
    localparam logic [7:0] HES_MASK_DIODE    = 8'hdb;
    localparam logic [7:0] HES_MASK_THROTTLE = 8'hff;
    localparam logic [7:0] HES_MASK_INPUTS   = 8'hff;
    localparam logic [7:0] HES_MASK_FANS     = 8'h0f;

    // throttle any, bin and full bits; these never feed the summary flag
    localparam logic [7:0] HES_THR_BIN_MASK  = 8'h7f;

    // throttle fraction is n/256; bin edges in counts
    localparam logic [8:0] HES_THR_12P5 = 9'h020;
    localparam logic [8:0] HES_THR_25   = 9'h040;
    localparam logic [8:0] HES_THR_50   = 9'h080;
    localparam logic [8:0] HES_THR_75   = 9'h0c0;
    localparam logic [8:0] HES_THR_FULL = 9'h100;

    localparam int HES_THR_ANY_BIT  = 0;
    localparam int HES_THR_FULL_BIT = 6;
    localparam int HES_THR_LIM_BIT  = 7;
    localparam int HES_NUM_REGS     = 6;

    typedef enum logic [1:0]
    {
        HES_SLEEP_S0  = 2'b00,
        HES_SLEEP_S1  = 2'b01,
        HES_SLEEP_S3  = 2'b10,
        HES_SLEEP_S45 = 2'b11
    } hes_sleep_e;

    // raw fault inputs grouped by register
    typedef struct packed
    {
        logic [3:0] chan_limit_fault;
        logic [3:0] further_limit_fault;
        logic       chan5_limit_fault;
        logic       diode1_secondary_fault;
        logic       diode2_secondary_fault;
        logic       diode1_primary_fault;
        logic       diode2_primary_fault;
        logic       fuse_monitor_input;
        logic       core_supply_mismatch;
        logic [3:0] fan_tach_fault;
    } hes_fault_s;

    // throttle interval result
    typedef struct packed
    {
        logic       done;
        logic [8:0] active_count;
        logic [8:0] user_limit;
    } hes_throttle_s;

    // per-register optional sleep masks (1 = suppress)
    typedef struct packed
    {
        logic [7:0] s1;
        logic [7:0] s3;
        logic [7:0] s45;
    } hes_sleep_mask_s;

endpackage

// >>> hes_throttle_bin.sv
// throttle interval classifier: builds the event byte for one interval
`timescale 1ns/1ps
module hes_throttle_bin
    import hes_pkg::*;
(
    input  wire hes_throttle_s thr_i,
    output logic [7:0]         events_o
);

    always_comb
    begin
        events_o = 8'h00;
        if (thr_i.done)
        begin
            events_o[HES_THR_ANY_BIT] = (thr_i.active_count != 9'h000);
            // half-open ranges, exactly one bin below full scale
            if (thr_i.active_count < HES_THR_12P5)
                events_o[1] = 1'b1;
            else if (thr_i.active_count < HES_THR_25)
                events_o[2] = 1'b1;
            else if (thr_i.active_count < HES_THR_50)
                events_o[3] = 1'b1;
            else if (thr_i.active_count < HES_THR_75)
                events_o[4] = 1'b1;
            else if (thr_i.active_count < HES_THR_FULL)
                events_o[5] = 1'b1;
            events_o[HES_THR_FULL_BIT] =
                (thr_i.active_count >= HES_THR_FULL);
            events_o[HES_THR_LIM_BIT] =
                (thr_i.active_count > thr_i.user_limit);
        end
    end

endmodule

// >>> hes_sticky_reg.sv
// one 8-bit sticky write-one-to-clear status register
`timescale 1ns/1ps
module hes_sticky_reg
    import hes_pkg::*;
#(
    parameter logic [7:0] IMPL_MASK = 8'hff
)
(
    input  wire logic       clk_sys_i,
    input  wire logic       rstn_i,
    input  wire logic [7:0] set_i,
    input  wire logic [7:0] clr_i,
    output logic [7:0]      value_o
);

    // set beats clear, so a still-present fault survives the clear
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            value_o <= HES_RESET_VALUE;
        else
            value_o <= ((value_o & ~clr_i) | set_i) & IMPL_MASK;
    end

endmodule

// >>> hes_host_model.sv
// host model: register reads and write-one-to-clear writes
`timescale 1ns/1ps
module hes_host_model
(
    input  wire logic  clk_sys_i,
    output logic       reg_wr_o,
    output logic       reg_rd_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o
);
    initial
    begin
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        reg_addr_o  = 8'h00;
        reg_wdata_o = 8'h00;
    end

    // released address and data lines show the inverse so a stale value never passes
    task automatic access(input logic wr, input logic [7:0] a,
                          input logic [7:0] d);
    begin
        @(posedge clk_sys_i);
        #1;
        reg_wr_o    = wr;
        reg_rd_o    = ~wr;
        reg_addr_o  = a;
        reg_wdata_o = d; // ones clear, zeros leave bits alone
        @(posedge clk_sys_i);
        #1;
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        reg_addr_o  = ~a;
        reg_wdata_o = ~d;
    end
    endtask
endmodule

// >>> hes_bank_tb_top.sv
// self-checking testbench for the host error status bank
`timescale 1ns/1ps
module hes_bank_tb_top
    import hes_pkg::*;
;
    logic          clk_sys_i;
    logic          rstn_i;
    hes_fault_s    fault;
    hes_throttle_s thr;
    logic [7:0]    pin_level;
    logic [7:0]    err_mask;
    logic          vid_older;
    hes_sleep_e    sleep;
    logic          reg_wr;
    logic          reg_rd;
    logic [7:0]    reg_addr;
    logic [7:0]    reg_wdata;
    logic [7:0]    reg_rdata;
    logic          reg_hit;
    logic          host_err;
    logic          rd_d = 1'b0;
    logic [31:0]   lfsr;
    logic [8:0]    exp_q[$];
    int            n_fail = 0;
    int            checks_done = 0;
    int            cycles = 0;
    hes_sleep_mask_s smask;
    int            cnt[10] = '{0, 1, 31, 32, 63, 64, 128, 191, 255, 256};
    logic [7:0]    addrs[6] = '{HES_ADDR_VOLT_A, HES_ADDR_VOLT_B,
        HES_ADDR_DIODE, HES_ADDR_THROTTLE, HES_ADDR_INPUTS, HES_ADDR_FANS};

    hes_bank u_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
        .fault_i(fault), .throttle_i(thr), .input_pin_level_i(pin_level),
        .input_error_mask_i(err_mask), .vid_mode_older_i(vid_older),
        .sleep_state_i(sleep), .sleep_mask_volt_b_i(smask),
        .sleep_mask_diode_i(smask), .sleep_mask_inputs_i(smask),
        .sleep_mask_fans_i(smask), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_rdata_o(reg_rdata), .reg_hit_o(reg_hit),
        .host_error_o(host_err));

    hes_host_model u_host (.clk_sys_i(clk_sys_i), .reg_wr_o(reg_wr),
        .reg_rd_o(reg_rd), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [7:0] thr_exp(input int n, input int lim);
        logic [7:0] e;
        e = 8'h00;
        e[0] = n > 0;
        if (n < 32) e[1] = 1'b1;
        else if (n < 64) e[2] = 1'b1;
        else if (n < 128) e[3] = 1'b1;
        else if (n < 192) e[4] = 1'b1;
        else if (n < 256) e[5] = 1'b1;
        e[6] = n == 256;
        e[7] = n > lim;
        return e;
    endfunction

    task automatic end_sim();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic bad(input string m);
        n_fail++;
        $display("MISMATCH t=%0t %s", $time, m);
    endtask

    task automatic cmp_rd(input logic [8:0] got, input logic [8:0] e);
        checks_done++;
        if (got !== e) bad($sformatf("read %h exp %h", got, e));
    endtask

    task automatic cmp_flag(input logic got, input logic e);
        checks_done++;
        if (got !== e) bad("summary flag");
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e,
                      input logic h = 1'b1);
        exp_q.push_back({h, e});
        u_host.access(1'b0, a, 8'h00);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_host.access(1'b1, a, d);
    endtask

    task automatic pulse(input hes_fault_s f);
        @(posedge clk_sys_i);
        #1 fault = f;
        @(posedge clk_sys_i);
        #1 fault = '0;
    endtask

    // read data lands at the taking edge and is checked one cycle later
    always @(posedge clk_sys_i)
    begin
        if (rd_d)
            cmp_rd({reg_hit, reg_rdata}, exp_q.pop_front());
        rd_d <= reg_rd && rstn_i;
        cycles <= cycles + 1;
        if (cycles == 4000)
        begin
            bad("timeout");
            end_sim();
        end
    end

    initial
    begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    initial
    begin
        hes_fault_s f;
        logic [7:0] e;
        {rstn_i, fault, thr, err_mask, vid_older, smask} = '0;
        pin_level = 8'hff;
        sleep = HES_SLEEP_S0;
        lfsr = 32'h436e;
        repeat (16) @(posedge clk_sys_i);
        #1 rstn_i = 1'b1;
        foreach (addrs[i]) rd(addrs[i], HES_RESET_VALUE);
        wr(8'h4d, 8'hff);
        rd(8'h4d, 8'h00, 1'b0);
        cmp_flag(host_err, 1'b0);
        $display("test reset done");
        f = '0;
        f.chan_limit_fault = 4'hf;
        f.further_limit_fault = 4'hf;
        f.chan5_limit_fault = 1'b1;
        pulse(f);
        rd(HES_ADDR_VOLT_A, 8'h47);
        rd(HES_ADDR_VOLT_B, 8'hf1);
        cmp_flag(host_err, 1'b1);
        wr(HES_ADDR_VOLT_A, 8'h00);
        rd(HES_ADDR_VOLT_A, 8'h47);
        wr(HES_ADDR_VOLT_A, 8'hff);
        wr(HES_ADDR_VOLT_B, 8'hff);
        rd(HES_ADDR_VOLT_A, 8'h00);
        cmp_flag(host_err, 1'b0);
        sleep = HES_SLEEP_S3;
        smask.s3 = 8'h10;
        pulse(f);
        rd(HES_ADDR_VOLT_A, 8'h00);
        rd(HES_ADDR_VOLT_B, 8'ha0);
        wr(HES_ADDR_VOLT_B, 8'hff);
        sleep = HES_SLEEP_S0;
        smask = '0;
        $display("test voltage done");
        f = '0;
        {f.diode1_secondary_fault, f.diode2_secondary_fault} = 2'b11;
        {f.diode1_primary_fault, f.diode2_primary_fault} = 2'b11;
        {f.fuse_monitor_input, f.core_supply_mismatch} = 2'b11;
        pulse(f);
        rd(HES_ADDR_DIODE, 8'hd3);
        wr(HES_ADDR_DIODE, 8'hff);
        vid_older = 1'b1;
        f = '0;
        f.fuse_monitor_input = 1'b1;
        pulse(f);
        rd(HES_ADDR_DIODE, 8'h08);
        wr(HES_ADDR_DIODE, 8'hff);
        $display("test diode done");
        @(posedge clk_sys_i);
        #1 fault.fan_tach_fault = 4'h5;
        wr(HES_ADDR_FANS, 8'hff);
        rd(HES_ADDR_FANS, 8'h05);
        fault = '0;
        wr(HES_ADDR_FANS, 8'hff);
        rd(HES_ADDR_FANS, 8'h00);
        sleep = HES_SLEEP_S45;
        f = '0;
        f.fan_tach_fault = 4'hf;
        pulse(f);
        rd(HES_ADDR_FANS, 8'h00);
        sleep = HES_SLEEP_S0;
        $display("test fans done");
        foreach (cnt[i])
        begin
            e = thr_exp(cnt[i], 128);
            @(posedge clk_sys_i);
            #1 thr = {1'b1, 9'(cnt[i]), 9'd128};
            @(posedge clk_sys_i);
            #1 thr.done = 1'b0;
            rd(HES_ADDR_THROTTLE, e);
            cmp_flag(host_err, e[7]);
            wr(HES_ADDR_THROTTLE, 8'hff);
        end
        $display("test throttle done");
        repeat (6)
        begin
            lfsr = lfsr_next(lfsr);
            @(posedge clk_sys_i);
            #1 {err_mask, pin_level} = lfsr[15:0];
            smask.s1 = lfsr[12:5];
            sleep = lfsr[0] ? HES_SLEEP_S1 : HES_SLEEP_S0;
            e = ~pin_level & ~err_mask;
            if (sleep == HES_SLEEP_S1)
                e = e & ~smask.s1;
            @(posedge clk_sys_i);
            #1 pin_level = 8'hff;
            rd(HES_ADDR_INPUTS, e);
            cmp_flag(host_err, |e);
            wr(HES_ADDR_INPUTS, 8'hff);
        end
        $display("test inputs done");
        sleep = HES_SLEEP_S0;
        f = '0;
        f.chan5_limit_fault = 1'b1;
        pulse(f);
        cmp_flag(host_err, 1'b1);
        @(posedge clk_sys_i);
        #1 rstn_i = 1'b0;
        @(posedge clk_sys_i);
        #1 rstn_i = 1'b1;
        rd(HES_ADDR_VOLT_B, HES_RESET_VALUE);
        cmp_flag(host_err, 1'b0);
        $display("test mid-run reset done");
        repeat (3) @(posedge clk_sys_i);
        end_sim();
    end
endmodule
